// ### pmclk_defs.vh
// register map, field positions, encodings and timing counts of the clock controller
`ifndef PMCLK_DEFS_VH
`define PMCLK_DEFS_VH

`define PMC_CTRL_ADDR     4'h0
`define PMC_STAT_ADDR     4'h4

`define PMC_CPU_GATE_BIT  7
`define PMC_FREQ_MSB      6
`define PMC_FREQ_LSB      4
`define PMC_PRI_RDY_BIT   3
`define PMC_FAST_STB_BIT  2
`define PMC_SRC_MSB       1
`define PMC_SRC_LSB       0

`define PMC_CTRL_RESET    8'h00
`define PMC_CTRL_WR_MASK  8'hf3

`define PMC_SRC_PRI       2'h0
`define PMC_SRC_SEC       2'h1
`define PMC_SRC_INT       2'h2
`define PMC_SRC_NONE      2'h3

`define PMC_FREQ_SLOW     3'h0
`define PMC_FREQ_FAST     3'h7
`define PMC_POST_ALL      7'h7f

`define PMC_PIN_XTAL      2'h0
`define PMC_PIN_CLKOUT    2'h1
`define PMC_PIN_PORT      2'h2

`define PMC_SWITCH_TICKS  4'h8
`define PMC_OST_TICKS     11'h400
`define PMC_SETTLE_TICKS  4'h8

`define PMC_CLK_MHZ       10
`define PMC_POR_WAIT_NS   5000
`define PMC_POR_CYCLES    ((`PMC_POR_WAIT_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_PLL_LOCK_NS   2000000
`define PMC_PLL_CYCLES    (`PMC_PLL_LOCK_NS * `PMC_CLK_MHZ / 1000)
`define PMC_POWERUP_DELAY_TIMER_CYCLES   16384

`define PMC_RESP_OKAY     2'h0
`define PMC_RESP_SLVERR   2'h2

`endif

// ### pmclk_ctrl.v
// power managed system clock controller with axi4-lite register access
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "pmclk_defs.vh"

// Behaviour
// - gate bit stops cpu in managed modes
// - three-bit code selects internal frequency
// - fast rc off when slow rc drives
// - primary ready flag after start-up count
// - fast rc stable flag, resets low
// - two-bit field picks clock source
// - primary ready resets to the inverse of two-speed enable
// - switch pauses 8 to 9 new periods
// - sleep command enters mode from control bits
// - primary runs only in primary modes
// - secondary clocks secondary modes, timers keep it
// - internal block clocks internal modes
// - sleep stops every unneeded source
// - slow rc runs while watchdog active
// - power-up timer holds reset when enabled
// - crystal start-up counts 1024 cycles
// - pll mode adds 2 ms lock wait
// - por wait 5 us runs concurrently
// - clock-out pin low or port in sleep
// - interrupt, reset, watchdog exit to primary run
// - run modes may enter sleep or idle
// - source field cleared on every reset
// - source field acts only at sleep
// - at most one source flag set
// - frequency change acts immediately
module pmclk_ctrl #(
    parameter integer POWERUP_DELAY_TIMER_CYCLES = `PMC_POWERUP_DELAY_TIMER_CYCLES,
    parameter integer PLL_CYCLES  = `PMC_PLL_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        pri_tick,
    input  wire        sec_tick,
    input  wire        fast_rc_tick,
    input  wire        slow_rc_tick,
    input  wire        sleep_cmd,
    input  wire        wake_irq,
    input  wire        wdt_timeout,
    input  wire        wdt_active,
    input  wire        timer_needs_sec,
    input  wire        sec_osc_enabled,
    input  wire        cfg_crystal,
    input  wire        cfg_pll,
    input  wire        cfg_powerup_delay_timer_en,
    input  wire        two_speed_startup_enable,
    input  wire [1:0]  cfg_pin_kind,
    output reg         core_reset_n,
    output wire        cpu_clk_en,
    output wire        periph_clk_en,
    output wire        pri_osc_en,
    output wire        sec_osc_en,
    output wire        fast_rc_en,
    output wire        slow_rc_en,
    output wire        xtal_inverter_en,
    output reg         clk_out_pin,
    output wire        clk_out_oe,
    output wire        clk_out_is_port,
    output wire [6:0]  pm_mode
);

    localparam [6:0] M_PRIMARY_RUN_MODE  = 7'h01;
    localparam [6:0] M_PRIMARY_IDLE_MODE = 7'h02;
    localparam [6:0] M_SECONDARY_RUN_MODE  = 7'h04;
    localparam [6:0] M_SECONDARY_IDLE_MODE = 7'h08;
    localparam [6:0] M_INT_RUN  = 7'h10;
    localparam [6:0] M_INT_IDLE = 7'h20;
    localparam [6:0] M_SLEEP    = 7'h40;

    // source field: 1x internal, 01 secondary, 00 primary
    function [1:0] field_src;
        input [1:0] f;
        begin
            if (f[1])
                field_src = `PMC_SRC_INT;
            else if (f[0])
                field_src = `PMC_SRC_SEC;
            else
                field_src = `PMC_SRC_PRI;
        end
    endfunction

    function [1:0] mode_src;
        input [6:0] m;
        begin
            case (m)
                M_PRIMARY_RUN_MODE, M_PRIMARY_IDLE_MODE: mode_src = `PMC_SRC_PRI;
                M_SECONDARY_RUN_MODE, M_SECONDARY_IDLE_MODE: mode_src = `PMC_SRC_SEC;
                M_INT_RUN, M_INT_IDLE: mode_src = `PMC_SRC_INT;
                default:               mode_src = `PMC_SRC_NONE;
            endcase
        end
    endfunction

    reg  [7:0]  ctrl_q;
    reg  [6:0]  mode_q;
    reg  [6:0]  mode_d;
    reg  [1:0]  cur_q;
    reg  [1:0]  nxt_q;
    reg         paus_q;
    reg  [3:0]  sw_cnt_q;
    reg  [6:0]  post_q;
    reg  [3:0]  settle_q;
    reg         stable_q;
    reg  [15:0] por_q;
    reg         por_done_q;
    reg  [31:0] powerup_delay_timer_q;
    reg         powerup_delay_timer_done_q;
    reg  [10:0] ost_q;
    reg         ost_done_q;
    reg  [31:0] pll_q;
    reg         pll_done_q;
    reg         pri_rdy_q;
    reg  [1:0]  div4_q;
    reg         aw_q;
    reg         w_q;
    reg  [3:0]  awaddr_q;
    reg  [7:0]  wbyte_q;
    reg         wlane_q;
    wire        cpu_gate  = ctrl_q[`PMC_CPU_GATE_BIT];
    wire [2:0]  freq      = ctrl_q[`PMC_FREQ_MSB:`PMC_FREQ_LSB];
    wire [1:0]  sel_src   = field_src(ctrl_q[`PMC_SRC_MSB:`PMC_SRC_LSB]);
    wire        in_sleep  = (mode_q == M_SLEEP);
    wire        run_mode  = (mode_q == M_PRIMARY_RUN_MODE) || (mode_q == M_SECONDARY_RUN_MODE) || (mode_q == M_INT_RUN);
    wire        pri_ready = ost_done_q && pll_done_q;
    wire        two_speed = two_speed_startup_enable && !pri_ready;
    // primary request rides on internal block until primary is ready
    wire [1:0]  tgt_src   = (mode_src(mode_q) == `PMC_SRC_PRI && two_speed) ?
                            `PMC_SRC_INT : mode_src(mode_q);
    // internal output: slow rc direct, or fast rc through postscaler
    wire [6:0]  post_mask = `PMC_POST_ALL >> freq;
    wire        post_hit  = ((post_q & post_mask) == post_mask);
    wire        int_tick  = (freq == `PMC_FREQ_SLOW) ? slow_rc_tick : (fast_rc_tick && post_hit);
    function src_tick;
        input [1:0] s;
        input       pt;
        input       st;
        input       it;
        begin
            case (s)
                `PMC_SRC_PRI: src_tick = pt;
                `PMC_SRC_SEC: src_tick = st;
                `PMC_SRC_INT: src_tick = it;
                default:      src_tick = 1'b0;
            endcase
        end
    endfunction
    wire        sys_tick  = !paus_q && src_tick(cur_q, pri_tick, sec_tick, int_tick);
    wire        new_tick  = src_tick(nxt_q, pri_tick, sec_tick, int_tick);
    wire        uses_int  = !in_sleep && ((cur_q == `PMC_SRC_INT) || (tgt_src == `PMC_SRC_INT) ||
                            (paus_q && nxt_q == `PMC_SRC_INT));
    wire        uses_sec  = !in_sleep && ((cur_q == `PMC_SRC_SEC) || (tgt_src == `PMC_SRC_SEC) ||
                            (paus_q && nxt_q == `PMC_SRC_SEC));
    assign pm_mode          = mode_q;
    assign cpu_clk_en       = sys_tick && core_reset_n && run_mode;
    assign periph_clk_en    = sys_tick && core_reset_n && !in_sleep;
    assign pri_osc_en       = (mode_q == M_PRIMARY_RUN_MODE) || (mode_q == M_PRIMARY_IDLE_MODE);
    assign sec_osc_en       = uses_sec || timer_needs_sec;
    assign fast_rc_en       = uses_int && (freq != `PMC_FREQ_SLOW);
    assign slow_rc_en       = (uses_int && freq == `PMC_FREQ_SLOW) || wdt_active;
    assign xtal_inverter_en = cfg_crystal && pri_osc_en;
    assign clk_out_oe       = (cfg_pin_kind == `PMC_PIN_CLKOUT);
    assign clk_out_is_port  = (cfg_pin_kind == `PMC_PIN_PORT);
    // power managed mode sequencing
    always @* begin
        mode_d = mode_q;
        if (wake_irq || wdt_timeout) begin
            mode_d = M_PRIMARY_RUN_MODE;
        end else if (sleep_cmd && run_mode && core_reset_n) begin
            case (sel_src)
                `PMC_SRC_PRI: mode_d = cpu_gate ? M_PRIMARY_IDLE_MODE : M_SLEEP;
                `PMC_SRC_SEC: begin
                    if (sec_osc_enabled)
                        mode_d = cpu_gate ? M_SECONDARY_IDLE_MODE : M_SECONDARY_RUN_MODE;
                end
                default:      mode_d = cpu_gate ? M_INT_IDLE : M_INT_RUN;
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn)
            mode_q <= M_PRIMARY_RUN_MODE;
        else
            mode_q <= mode_d;
    end
    // glitch-free switch: count eight ticks of the new source
    always @(posedge aclk) begin
        if (!aresetn) begin
            cur_q    <= `PMC_SRC_PRI;
            nxt_q    <= `PMC_SRC_PRI;
            paus_q   <= 1'b0;
            sw_cnt_q <= 4'h0;
        end else if (paus_q && tgt_src != nxt_q) begin
            nxt_q    <= tgt_src;
            sw_cnt_q <= 4'h0;
        end else if (paus_q) begin
            if (new_tick) begin
                if (sw_cnt_q == `PMC_SWITCH_TICKS - 4'h1) begin
                    cur_q  <= nxt_q;
                    paus_q <= 1'b0;
                end
                sw_cnt_q <= sw_cnt_q + 4'h1;
            end
        end else if (tgt_src != cur_q) begin
            paus_q   <= 1'b1;
            nxt_q    <= tgt_src;
            sw_cnt_q <= 4'h0;
        end
    end
    // fast rc postscaler and settling
    always @(posedge aclk) begin
        if (!aresetn) begin
            post_q   <= 7'h00;
            settle_q <= 4'h0;
            stable_q <= 1'b0;
        end else if (!fast_rc_en) begin
            post_q   <= 7'h00;
            settle_q <= 4'h0;
            stable_q <= 1'b0;
        end else if (fast_rc_tick) begin
            post_q <= post_q + 7'h01;
            if (settle_q == `PMC_SETTLE_TICKS - 4'h1)
                stable_q <= 1'b1;
            else
                settle_q <= settle_q + 4'h1;
        end
    end
    // power-up delays, all running side by side
    always @(posedge aclk) begin
        if (!aresetn) begin
            por_q       <= 16'h0000;
            por_done_q  <= 1'b0;
            powerup_delay_timer_q      <= 32'h00000000;
            powerup_delay_timer_done_q <= 1'b0;
        end else begin
            if (!por_done_q) begin
                por_q <= por_q + 16'h0001;
                if (por_q == `PMC_POR_CYCLES - 1)
                    por_done_q <= 1'b1;
            end
            if (!cfg_powerup_delay_timer_en) begin
                powerup_delay_timer_done_q <= 1'b1;
            end else if (!powerup_delay_timer_done_q) begin
                powerup_delay_timer_q <= powerup_delay_timer_q + 32'h00000001;
                if (powerup_delay_timer_q == POWERUP_DELAY_TIMER_CYCLES - 1)
                    powerup_delay_timer_done_q <= 1'b1;
            end
        end
    end
    // crystal start-up and pll lock, restarted whenever primary stops
    always @(posedge aclk) begin
        if (!aresetn || !pri_osc_en) begin
            ost_q      <= 11'h000;
            ost_done_q <= 1'b0;
            pll_q      <= 32'h00000000;
            pll_done_q <= 1'b0;
        end else begin
            if (!cfg_crystal) begin
                ost_done_q <= 1'b1;
            end else if (!ost_done_q && pri_tick) begin
                ost_q <= ost_q + 11'h001;
                if (ost_q == `PMC_OST_TICKS - 11'h001)
                    ost_done_q <= 1'b1;
            end
            if (!cfg_pll) begin
                pll_done_q <= ost_done_q;
            end else if (ost_done_q && !pll_done_q) begin
                pll_q <= pll_q + 32'h00000001;
                if (pll_q == PLL_CYCLES - 1)
                    pll_done_q <= 1'b1;
            end
        end
    end
    // core held until every delay that applies has run out
    always @(posedge aclk) begin
        if (!aresetn)
            core_reset_n <= 1'b0;
        else if (!core_reset_n)
            core_reset_n <= por_done_q && powerup_delay_timer_done_q &&
                            (pri_ready || two_speed_startup_enable);
    end
    // primary ready flag, shown only while primary drives
    always @(posedge aclk) begin
        if (!aresetn || !core_reset_n)
            pri_rdy_q <= !two_speed_startup_enable;
        else
            pri_rdy_q <= pri_ready && cur_q == `PMC_SRC_PRI && !paus_q;
    end
    wire fast_flag = stable_q && cur_q == `PMC_SRC_INT && !paus_q;
    wire sec_flag  = cur_q == `PMC_SRC_SEC && !paus_q;
    // clock/4 output, held low in sleep
    always @(posedge aclk) begin
        if (!aresetn) begin
            div4_q      <= 2'h0;
            clk_out_pin <= 1'b0;
        end else if (in_sleep || cfg_pin_kind != `PMC_PIN_CLKOUT) begin
            div4_q      <= 2'h0;
            clk_out_pin <= 1'b0;
        end else if (sys_tick) begin
            div4_q      <= div4_q + 2'h1;
            clk_out_pin <= div4_q[1];
        end
    end

    // axi4-lite write channel
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            awaddr_q     <= 4'h0;
            wbyte_q      <= 8'h00;
            wlane_q      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PMC_RESP_OKAY;
            ctrl_q       <= `PMC_CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q     <= 1'b1;
                wbyte_q <= s_axi_wdata[7:0];
                wlane_q <= s_axi_wstrb[0];
            end
            if (aw_q && w_q && !s_axi_bvalid) begin
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_q == `PMC_CTRL_ADDR) begin
                    s_axi_bresp <= `PMC_RESP_OKAY;
                    if (wlane_q)
                        ctrl_q <= (ctrl_q & ~`PMC_CTRL_WR_MASK) |
                                  (wbyte_q & `PMC_CTRL_WR_MASK);
                end else if (awaddr_q == `PMC_STAT_ADDR) begin
                    s_axi_bresp <= `PMC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `PMC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `PMC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `PMC_RESP_OKAY;
            case (s_axi_araddr)
                `PMC_CTRL_ADDR: s_axi_rdata <= {24'h000000, ctrl_q[7:4], pri_rdy_q,
                                                fast_flag, ctrl_q[1:0]};
                `PMC_STAT_ADDR: s_axi_rdata <= {21'h000000, paus_q, core_reset_n,
                                                sec_flag, 1'b0, mode_q};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `PMC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // pmclk_ctrl

// ### pmclk_ctrl_assertions.sv
// assertion checker bound to the clock controller top
`timescale 1ns/10ps
module pmclk_chk (
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        sleep_cmd,
    input logic        wake_irq,
    input logic        wdt_timeout,
    input logic        wdt_active,
    input logic        core_reset_n,
    input logic        cpu_clk_en,
    input logic        periph_clk_en,
    input logic        pri_osc_en,
    input logic        fast_rc_en,
    input logic        slow_rc_en,
    input logic        xtal_inverter_en,
    input logic        clk_out_pin,
    input logic        clk_out_oe,
    input logic [1:0]  cfg_pin_kind,
    input logic [6:0]  pm_mode
);
    // no wake pending, so mode-based enables are steady
    wire quiet = !wake_irq && !wdt_timeout;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_mode_onehot: assert property ($onehot(pm_mode))
        else $error("mode not one-hot");
    a_cpu_gated_idle: assert property (quiet && (pm_mode & 7'h6a) != 7'h00 |-> !cpu_clk_en)
        else $error("cpu clocked in idle or sleep");
    a_sleep_all_off: assert property (quiet && pm_mode == 7'h40 |-> !periph_clk_en && !fast_rc_en && !xtal_inverter_en)
        else $error("source alive in sleep");
    a_pri_off_else: assert property (quiet && (pm_mode & 7'h7c) != 7'h00 |-> !pri_osc_en)
        else $error("primary left running");
    a_wdt_slow_rc: assert property (wdt_active |-> slow_rc_en)
        else $error("slow rc off under watchdog");
    a_wake_primary_run_mode: assert property (wake_irq || wdt_timeout |=> pm_mode == 7'h01)
        else $error("wake not to primary run");
    a_reset_state: assert property ($rose(aresetn) |-> pm_mode == 7'h01 && !core_reset_n && !s_axi_bvalid)
        else $error("bad state after reset");
    a_clkout_low: assert property (pm_mode == 7'h40 && $past(pm_mode) == 7'h40 && cfg_pin_kind == 2'h1
        |-> !clk_out_pin && clk_out_oe) else $error("clock out not low in sleep");
    a_switch_pause: assert property ($past(pm_mode) == 7'h01 && (pm_mode & 7'h3c) != 7'h00
        |=> (!periph_clk_en) [*8]) else $error("switch pause too short");

    c_sleep: cover property (sleep_cmd ##1 pm_mode == 7'h40);
    c_secondary_idle_mode: cover property (pm_mode == 7'h08);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // pmclk_chk

bind pmclk_ctrl pmclk_chk chk_u (.*);

// ### tb.sv
// self-checking bench of the power managed clock controller
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        pri_tick = 1'b0, sec_tick = 1'b0, fast_rc_tick = 1'b0, slow_rc_tick = 1'b0;
    logic        sleep_cmd = 1'b0, wake_irq = 1'b0, wdt_timeout = 1'b0;
    logic        wdt_active = 1'b0, timer_needs_sec = 1'b0, sec_osc_enabled = 1'b0;
    logic        two_speed_startup_enable = 1'b0;
    logic [1:0]  cfg_pin_kind = 2'h1;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         core_reset_n, cpu_clk_en, periph_clk_en, pri_osc_en, sec_osc_en, fast_rc_en;
    wire         slow_rc_en, xtal_inverter_en, clk_out_pin, clk_out_oe, clk_out_is_port;
    wire  [6:0]  pm_mode;
    int          errors = 0, checked = 0, cyc = 0, held = 0;
    logic [31:0] rd;
    logic [1:0]  r;

    pmclk_ctrl #(.POWERUP_DELAY_TIMER_CYCLES(8), .PLL_CYCLES(8)) dut_u (
        .cfg_crystal(1'b1),
        .cfg_pll(1'b1),
        .cfg_powerup_delay_timer_en(1'b1),
        .*
    );

    always #50 aclk = ~aclk;

    // source ticks of unlike periods, plus run limit
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        pri_tick <= (cyc % 2 == 0);
        fast_rc_tick <= (cyc % 4 == 0);
        sec_tick <= (cyc % 5 == 0);
        slow_rc_tick <= (cyc % 7 == 0);
        if (!aresetn) held <= 0;
        else if (!core_reset_n && pri_tick) held <= held + 1;
        if (cyc == 20000) begin
            errors++;
            give_verdict;
        end
    end

    task automatic give_verdict;
        if (errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awready) ad = 1'b1;
            if (s_axi_wready) wd = 1'b1;
            if (ad) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        rd = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    function automatic logic tick_of(input logic [2:0] c);
        return c[1:0] == 2'h1 ? sec_tick : c[1] ? (c[0] ? slow_rc_tick : fast_rc_tick) : pri_tick;
    endfunction

    task automatic rst_check(input logic ts, input logic [1:0] pk);
        @(posedge aclk);
        aresetn <= 1'b0;
        two_speed_startup_enable <= ts;
        cfg_pin_kind <= pk;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axr(4'h0);
        `CHK(rd[7:0], {4'h0, !ts, 3'h0})
        axr(4'h4);
        `CHK(rd[9:0], 10'h001)
        `CHK({clk_out_oe, clk_out_is_port}, {pk == 2'h1, pk == 2'h2})
    endtask

    task automatic t_startup;
        sec_osc_enabled <= 1'b1;
        while (!core_reset_n) @(posedge aclk);
        `CHK(held >= 1024 && held <= 1040, 1'b1)
    endtask

    task automatic t_regs;
        axw(4'h0, 32'hff, 4'hf);
        `CHK(r, 2'h0)
        `CHK(pm_mode, 7'h01)
        axr(4'h0);
        `CHK(rd[7:0], 8'hfb)
        axw(4'h0, 32'h0, 4'h0);
        axr(4'h0);
        `CHK(rd[7:0], 8'hfb)
        axr(4'h8);
        `CHK({r, rd}, {2'h2, 32'h0})
        axw(4'hc, 32'h0, 4'hf);
        `CHK(r, 2'h2)
    endtask

    task automatic enter(input logic [7:0] v, input logic [6:0] m);
        axw(4'h0, {24'h0, v}, 4'hf);
        @(posedge aclk);
        sleep_cmd <= 1'b1;
        @(posedge aclk);
        sleep_cmd <= 1'b0;
        @(negedge aclk);
        `CHK(pm_mode, m)
    endtask

    task automatic t_modes;
        logic [2:0] codes [8] = '{3'h4, 3'h0, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
        logic [2:0] c, f;
        logic [6:0] m;
        int n;
        for (int j = 0; j < 8; j++) begin
            c = codes[j];
            f = c[1] ? (c[0] ? 3'h0 : 3'h7) : j[2:0] + 3'h1;
            m = c[1:0] == 2'h0 ? (c[2] ? 7'h02 : 7'h40) : c[1] ? (c[2] ? 7'h20 : 7'h10) : (c[2] ? 7'h08 : 7'h04);
            @(posedge aclk);
            wdt_active <= j[0];
            timer_needs_sec <= (c == 3'h0);
            enter({c[2], f, 2'h0, c[1:0]}, m);
            n = 0;
            if (c != 3'h0) begin
                // pause starts one edge after the mode changes
                @(negedge aclk);
                while (!periph_clk_en && n < 20) begin
                    n += tick_of(c);
                    @(negedge aclk);
                end
                `CHK(cpu_clk_en, periph_clk_en && !c[2])
                n += tick_of(c);
                if (c[1:0] != 2'h0) `CHK(n >= 8 && n <= 9, 1'b1)
            end
            @(negedge aclk);
            `CHK(pri_osc_en, c == 3'h4)
            `CHK(sec_osc_en, c[1:0] == 2'h1 || c == 3'h0)
            `CHK(slow_rc_en, c[1:0] == 2'h3 || j[0])
            if (c[1:0] == 2'h3) `CHK(fast_rc_en, 1'b0)
            if (c == 3'h0) begin
                `CHK({fast_rc_en, xtal_inverter_en, clk_out_pin, clk_out_oe, clk_out_is_port}, 5'h02)
            end else begin
                axr(4'h0);
                `CHK(rd[7:0], {c[2], f, c == 3'h4, c[1:0] == 2'h2, c[1:0]})
                axr(4'h4);
                `CHK(rd[8], c[1:0] == 2'h1)
            end
            if (c == 3'h1) enter({1'b1, f, 4'h1}, 7'h08);
            @(posedge aclk);
            wake_irq <= !j[0];
            wdt_timeout <= j[0];
            @(posedge aclk);
            wake_irq <= 1'b0;
            wdt_timeout <= 1'b0;
            @(negedge aclk);
            `CHK(pm_mode, 7'h01)
        end
    endtask

    initial begin
        rst_check(1'b0, 2'h1);
        t_startup;
        t_regs;
        t_modes;
        rst_check(1'b1, 2'h2);
        give_verdict;
    end
endmodule // tb
